//--- hw/pil_pkg.sv
// pil_pkg: constants and types of the port indicator block
// assumes a 200 MHz core clock and four downstream ports
package pil_pkg;
  localparam int unsigned NUM_PORTS     = 4;
  localparam int unsigned STATE_W       = 4;
  localparam int unsigned CODE_W        = 3;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned BLINK_HALF_NS = 500000000;
  localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned MOD_HALF_NS   = 50;
  localparam int unsigned MOD_HALF_CYCLES = MOD_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned BLINK_CNT_W   = 27;
  localparam int unsigned MOD_CNT_W     = 4;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MANUAL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  // control fields
  localparam int unsigned CTRL_MANUAL_BIT = 0;
  localparam int unsigned CTRL_POL_BIT    = 1;
  localparam int unsigned CTRL_MOD_BIT    = 2;
  localparam logic [2:0]  CTRL_RESET      = 3'h0;
  localparam logic [11:0] MANUAL_RESET    = 12'h000;
  // status fields
  localparam int unsigned STAT_GREEN_POS  = 0;
  localparam int unsigned STAT_AMBER_POS  = 4;
  localparam int unsigned STAT_MODE_POS   = 8;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;
  // colour selections written by software in manual mode
  typedef enum logic [2:0] {
    PIL_OFF         = 3'h0,
    PIL_AMBER       = 3'h1,
    PIL_GREEN       = 3'h2,
    PIL_BLINK_GREEN = 3'h3,
    PIL_BLINK_AMBER = 3'h4,
    PIL_BLINK_RSVD  = 3'h5
  } pil_code_t;
  // port state machine states as delivered on the state input
  typedef enum logic [3:0] {
    PS_POWERED_OFF   = 4'h0,
    PS_DISCONNECTED  = 4'h1,
    PS_DISABLED      = 4'h2,
    PS_NOT_CONFIG    = 4'h3,
    PS_RESETTING     = 4'h4,
    PS_TESTING       = 4'h5,
    PS_ENABLED       = 4'h6,
    PS_TRANSMIT      = 4'h7,
    PS_TRANSMIT_R    = 4'h8,
    PS_SUSPENDED     = 4'h9,
    PS_RESUMING      = 4'hA,
    PS_SEND_EOR      = 4'hB,
    PS_RESTART       = 4'hC
  } pil_pstate_t;
endpackage : pil_pkg

//--- hw/pil_tick_if.sv
// pil_tick_if: carries blink and modulation phases between pil modules
// assumes both ends run on the same core clock
`timescale 1ns/10ps
interface pil_tick_if;
  logic blink_phase;
  logic mod_phase;
  modport gen (output blink_phase, output mod_phase);
  modport use_side (input blink_phase, input mod_phase);
endinterface : pil_tick_if

//--- hw/pil_tick_gen.sv
// pil_tick_gen: slow blink phase and fast modulation square wave
// assumes a synchronised active-low reset on the core clock
`timescale 1ns/10ps
module pil_tick_gen #(
  parameter int unsigned BLINK_HALF = pil_pkg::BLINK_HALF_CYCLES
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  pil_tick_if.gen     tick
);
  logic [pil_pkg::BLINK_CNT_W-1:0] blink_cnt;
  logic [pil_pkg::MOD_CNT_W-1:0]   mod_cnt;

  // equal halves, terminal count from the parameter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt        <= '0;
      tick.blink_phase <= 1'b0;
    end else if (blink_cnt == pil_pkg::BLINK_CNT_W'(BLINK_HALF - 1)) begin
      blink_cnt        <= '0;
      tick.blink_phase <= ~tick.blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  // square wave for power saving modulation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_cnt        <= '0;
      tick.mod_phase <= 1'b0;
    end else if (mod_cnt ==
                 pil_pkg::MOD_CNT_W'(pil_pkg::MOD_HALF_CYCLES - 1)) begin
      mod_cnt        <= '0;
      tick.mod_phase <= ~tick.mod_phase;
    end else begin
      mod_cnt <= mod_cnt + 1'b1;
    end
  end
endmodule : pil_tick_gen

//--- hw/pil_top.sv
// pil_top: two-colour port indicator control for four hub ports
// assumes port state, overcurrent and babble inputs come from core-clock
// logic of the hub, and an AHB-Lite master with single word transfers
//
// Overview of operation
// - auto mode: powered-off port dark, amber if power cut by overcurrent
// - auto mode: both colours off in all inactive port states
// - auto mode: green lit in Enabled, Transmit or TransmitR
// - outputs may be square-wave modulated to save LED power
// - active output level selectable, low or high means lit
// - manual mode: host-selected colour is shown unless overcurrent or babble overrides it
// - blinking patterns available in manual mode
// - manual mode: babble blinks green, overcurrent shows steady amber
// - manual: off/green blinking means software attention; steady meanings
// - manual: off/amber blinking means hardware attention
// - reset starts in automatic mode without blinking
`timescale 1ns/10ps
module pil_top #(
  parameter int unsigned BLINK_HALF = pil_pkg::BLINK_HALF_CYCLES
) (
  input  wire logic                                        REF_CLK,
  input  wire logic                                        RST_N,
  input  wire logic                                        HSEL,
  input  wire logic [31:0]                                 HADDR,
  input  wire logic [1:0]                                  HTRANS,
  input  wire logic                                        HWRITE,
  input  wire logic [2:0]                                  HSIZE,
  input  wire logic [31:0]                                 HWDATA,
  input  wire logic                                        HREADY,
  output logic      [31:0]                                 HRDATA,
  output logic                                             HREADYOUT,
  output logic                                             HRESP,
  input  wire logic [pil_pkg::NUM_PORTS*pil_pkg::STATE_W-1:0] PORT_STATE,
  input  wire logic [pil_pkg::NUM_PORTS-1:0]               PORT_OVC_OFF,
  input  wire logic [pil_pkg::NUM_PORTS-1:0]               PORT_OVC,
  input  wire logic [pil_pkg::NUM_PORTS-1:0]               PORT_BABBLE,
  output logic      [pil_pkg::NUM_PORTS-1:0]               LED_GREEN,
  output logic      [pil_pkg::NUM_PORTS-1:0]               LED_AMBER
);
  localparam int unsigned NP = pil_pkg::NUM_PORTS;
  localparam int unsigned CW = pil_pkg::CODE_W;

  logic              rst_meta;
  logic              rst_n;
  logic [2:0]        ctrl;
  logic [NP*CW-1:0]  manual;
  logic [2:0]        next_ctrl;
  logic [NP*CW-1:0]  next_manual;
  logic              wr_pend;
  logic [7:0]        wr_addr;
  logic              rd_req;
  logic [7:0]        rd_addr;
  logic [NP-1:0]     lit_green;
  logic [NP-1:0]     lit_amber;
  logic [31:0]       next_rdata;

  pil_tick_if tick ();

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  pil_tick_gen #(
    .BLINK_HALF (BLINK_HALF)
  ) u_tick (
    .clk   (REF_CLK),
    .rst_n (rst_n),
    .tick  (tick.gen)
  );

  // AHB-Lite slave: zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP     = pil_pkg::HRESP_OKAY;
  assign rd_req    = HSEL && HREADY && (HTRANS == pil_pkg::HTRANS_NONSEQ)
                     && !HWRITE;
  assign rd_addr   = HADDR[7:0];

  // address phase of a write is held until its data phase
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (HREADY) begin
      wr_pend <= HSEL && (HTRANS == pil_pkg::HTRANS_NONSEQ) && HWRITE;
      wr_addr <= HADDR[7:0];
    end
  end

  always_comb begin
    next_ctrl   = ctrl;
    next_manual = manual;
    if (wr_pend && wr_addr == pil_pkg::OFS_CTRL) begin
      next_ctrl = HWDATA[2:0];
    end else if (wr_pend && wr_addr == pil_pkg::OFS_MANUAL) begin
      next_manual = HWDATA[NP*CW-1:0];
    end
  end

  // host selection is stored as written; hardware faults and reserved codes change what is shown
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl   <= pil_pkg::CTRL_RESET; // automatic, active low
      manual <= pil_pkg::MANUAL_RESET;
    end else begin
      ctrl   <= next_ctrl;
      manual <= next_manual;
    end
  end

  // control and manual read data built from next values so a write just ahead is seen; status uses current values
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_addr == pil_pkg::OFS_CTRL) begin
      next_rdata[2:0] = next_ctrl;
    end else if (rd_addr == pil_pkg::OFS_MANUAL) begin
      next_rdata[NP*CW-1:0] = next_manual;
    end else if (rd_addr == pil_pkg::OFS_STATUS) begin
      next_rdata[pil_pkg::STAT_GREEN_POS +: NP] = lit_green;
      next_rdata[pil_pkg::STAT_AMBER_POS +: NP] = lit_amber;
      next_rdata[pil_pkg::STAT_MODE_POS] = ctrl[pil_pkg::CTRL_MANUAL_BIT];
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA <= 32'h0000_0000;
    end else if (rd_req) begin
      HRDATA <= next_rdata;
    end
  end

  // per-port colour decision
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_port
      pil_pkg::pil_pstate_t pst;
      pil_pkg::pil_code_t   code;
      logic                 auto_g;
      logic                 auto_a;
      logic                 man_g;
      logic                 man_a;
      logic                 drv_g;
      logic                 drv_a;

      assign pst  = pil_pkg::pil_pstate_t'(PORT_STATE[gi*pil_pkg::STATE_W +:
                                                     pil_pkg::STATE_W]);
      assign code = pil_pkg::pil_code_t'(manual[gi*CW +: CW]);

      // automatic mode follows the port state, never blinks
      always_comb begin
        auto_g = 1'b0;
        auto_a = 1'b0;
        case (pst)
          pil_pkg::PS_POWERED_OFF: auto_a = PORT_OVC_OFF[gi];
          pil_pkg::PS_ENABLED,
          pil_pkg::PS_TRANSMIT,
          pil_pkg::PS_TRANSMIT_R:  auto_g = 1'b1;
          default: begin
            auto_g = 1'b0; // inactive states stay dark
            auto_a = 1'b0;
          end
        endcase
      end

      // manual mode: hardware faults override the host choice
      always_comb begin
        man_g = 1'b0;
        man_a = 1'b0;
        if (PORT_OVC[gi]) begin
          man_a = 1'b1; // steady amber only
        end else if (PORT_BABBLE[gi]) begin
          man_g = tick.blink_phase; // blinking green
        end else begin
          case (code)
            pil_pkg::PIL_AMBER:       man_a = 1'b1; // error
            pil_pkg::PIL_GREEN:       man_g = 1'b1; // operational
            pil_pkg::PIL_BLINK_GREEN: man_g = tick.blink_phase;
            pil_pkg::PIL_BLINK_AMBER: man_a = tick.blink_phase;
            // reserved pattern is shown dark rather than guessed
            default: begin
              man_g = 1'b0;
              man_a = 1'b0;
            end
          endcase
        end
      end

      assign lit_green[gi] = ctrl[pil_pkg::CTRL_MANUAL_BIT] ? man_g : auto_g;
      assign lit_amber[gi] = ctrl[pil_pkg::CTRL_MANUAL_BIT] ? man_a : auto_a;

      // modulation only chops lit lines; dark lines stay steady
      assign drv_g = lit_green[gi] &
                     (~ctrl[pil_pkg::CTRL_MOD_BIT] | tick.mod_phase);
      assign drv_a = lit_amber[gi] &
                     (~ctrl[pil_pkg::CTRL_MOD_BIT] | tick.mod_phase);

      // registered pins, reset to the dark level of active-low polarity
      always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
          LED_GREEN[gi] <= 1'b1;
          LED_AMBER[gi] <= 1'b1;
        end else begin
          LED_GREEN[gi] <= drv_g ~^ ctrl[pil_pkg::CTRL_POL_BIT];
          LED_AMBER[gi] <= drv_a ~^ ctrl[pil_pkg::CTRL_POL_BIT];
        end
      end
    end
  endgenerate
endmodule : pil_top

//--- verification/pil_led_model.sv
// pil_led_model: green and amber lamps of the four hub ports
// assumes the lamp glows when its line sits at the lit level
`timescale 1ns/10ps
module pil_led_model (
  input  wire logic       pol,
  input  wire logic [3:0] green,
  input  wire logic [3:0] amber,
  output logic      [3:0] lit_g,
  output logic      [3:0] lit_a
);
  // an undriven line gives an unknown lamp, so it never counts as a match
  assign lit_g = pol ? green : ~green;
  assign lit_a = pol ? amber : ~amber;
endmodule : pil_led_model

//--- verification/pil_top_sva.sv
// pil_top_chk: pin checks of the indicator block on port 0
// assumes one AHB slave and a BLINK_HALF equal to the design's
`timescale 1ns/10ps
module pil_top_chk #(
  parameter int unsigned BLINK_HALF = 8
) (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [15:0] PORT_STATE,
  input wire logic [3:0]  PORT_OVC_OFF,
  input wire logic [3:0]  PORT_OVC,
  input wire logic [3:0]  PORT_BABBLE,
  input wire logic [3:0]  LED_GREEN,
  input wire logic [3:0]  LED_AMBER
);
  logic        wr_p;
  logic [7:0]  a_p;
  logic [2:0]  ctrl;
  logic [2:0]  code;
  logic [12:0] cfg;
  logic [12:0] cfg_q;
  logic [7:0]  cfg_cnt;
  logic [7:0]  cfg_run;
  logic        g_q;
  logic [7:0]  run_g;
  logic        lg;
  logic        la;
  logic        au;
  logic        pl;
  assign cfg = {ctrl, code, PORT_STATE[3:0], PORT_OVC_OFF[0], PORT_OVC[0],
                PORT_BABBLE[0]};
  // zero on the very edge a change is first seen, while the pins still lag
  assign cfg_run = (cfg != cfg_q) ? 8'h00 : cfg_cnt;
  assign lg = LED_GREEN[0] == ctrl[1];
  assign la = LED_AMBER[0] == ctrl[1];
  // four quiet edges cover the reset release and the one-cycle pin lag
  assign au = cfg_run >= 8'h04 && !ctrl[2] && !ctrl[0];
  assign pl = cfg_run >= 8'h04 && !ctrl[2] && ctrl[0] && !PORT_OVC[0] &&
              !PORT_BABBLE[0];
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_p <= 1'b0;
      a_p  <= 8'h00;
      ctrl <= 3'h0;
      code <= 3'h0;
    end else begin
      wr_p <= HSEL && HREADY && HTRANS == 2'h2 && HWRITE;
      a_p  <= HADDR[7:0];
      if (wr_p && a_p == 8'h00) ctrl <= HWDATA[2:0];
      if (wr_p && a_p == 8'h04) code <= HWDATA[2:0];
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q   <= 13'h0000;
      cfg_cnt <= 8'h00;
      g_q     <= 1'b1;
      run_g   <= 8'h00;
    end else begin
      cfg_q   <= cfg;
      cfg_cnt <= cfg_run + {7'h00, cfg_run != 8'hFF};
      g_q     <= LED_GREEN[0];
      run_g   <= (LED_GREEN[0] != g_q) ? 8'h01 : run_g + 8'h01;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence amb_blink_s;
    !lg ##[0:8] (la || cfg_run == 8'h00);
  endsequence
  off_ovc_a: assert property (au && PORT_STATE[3:0] == 4'h0
    |-> !lg && la == PORT_OVC_OFF[0]) else $error("powered-off colour");
  auto_dark_a: assert property (au && PORT_STATE[3:0] inside
    {[4'h1:4'h5], [4'h9:4'hC]} |-> !lg && !la) else $error("not dark");
  auto_green_a: assert property (au && PORT_STATE[3:0] inside
    {[4'h6:4'h8]} |-> lg && !la) else $error("green not lit");
  mod_wave_a: assert property (
    cfg_run >= 8'h1E && ctrl[2] && !ctrl[0] && PORT_STATE[3:0] == 4'h6
    |-> ##[1:11] ($changed(LED_GREEN[0]) || cfg_run == 8'h00))
    else $error("no modulation");
  steady_code_a: assert property (
    pl && code inside {[3'h0:3'h2]}
    |-> lg == (code == 3'h2) && la == (code == 3'h1)) else $error("code");
  man_ovc_a: assert property (
    cfg_run >= 8'h04 && ctrl[0] && !ctrl[2] && PORT_OVC[0]
    |-> la && !lg) else $error("overcurrent not steady amber");
  blink_half_a: assert property (
    cfg_run >= 8'h13 && !ctrl[2] && $changed(LED_GREEN[0])
    |-> run_g == BLINK_HALF) else $error("blink half");
  amber_blink_a: assert property (pl && code == 3'h4
    |-> amb_blink_s) else $error("amber not blinking");
endmodule : pil_top_chk
bind pil_top pil_top_chk #(.BLINK_HALF(BLINK_HALF)) u_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .PORT_STATE(PORT_STATE), .PORT_OVC_OFF(PORT_OVC_OFF), .PORT_OVC(PORT_OVC),
  .PORT_BABBLE(PORT_BABBLE), .LED_GREEN(LED_GREEN), .LED_AMBER(LED_AMBER));

//--- verification/port_indicator_led_control_tb.sv
// port_indicator_led_control_tb: random and corner runs of pil_top
// assumes pil_pkg, the design and the lamp model are compiled first
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module port_indicator_led_control_tb;
  logic        REF_CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        HSEL = 1'b0;
  logic        HWRITE = 1'b0;
  logic [1:0]  HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
  logic        HREADYOUT, HRESP;
  logic [15:0] PORT_STATE = 16'h0000;
  logic [3:0]  PORT_OVC_OFF = 4'h0, PORT_OVC = 4'h0, PORT_BABBLE = 4'h0;
  logic [3:0]  LED_GREEN, LED_AMBER, lit_g, lit_a;
  logic [2:0]  ctrl = 3'h0;
  logic [11:0] man = 12'h000;
  logic [11:0] got [4];
  integer      seed = 32'h40377337, err_total = 0, n_compared = 0, cyc = 0;
  pil_top #(.BLINK_HALF(8)) u_dut (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .PORT_STATE(PORT_STATE), .PORT_OVC_OFF(PORT_OVC_OFF),
    .PORT_OVC(PORT_OVC), .PORT_BABBLE(PORT_BABBLE), .LED_GREEN(LED_GREEN),
    .LED_AMBER(LED_AMBER));
  pil_led_model u_led (.pol(ctrl[1]), .green(LED_GREEN), .amber(LED_AMBER),
    .lit_g(lit_g), .lit_a(lit_a));
  initial forever #2.5 REF_CLK = ~REF_CLK;
  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR  <= {24'h0, a};
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    `CHK(HRESP, 1'b0)
  endtask : ahb
  // lit cycles per port, green count above amber count
  task automatic win(input int n);
    repeat (6) @(posedge REF_CLK);
    for (int p = 0; p < 4; p++) got[p] = 12'h000;
    repeat (n) begin
      @(negedge REF_CLK);
      for (int p = 0; p < 4; p++)
        got[p] += {5'h00, lit_g[p], 5'h00, lit_a[p]};
    end
  endtask : win
  // a 16-cycle window spans exactly one blink period, whatever its phase
  function automatic logic [11:0] expc(input int p);
    logic [3:0] s;
    logic [5:0] g;
    logic [5:0] a;
    s = PORT_STATE[4*p+:4];
    g = 6'h00;
    a = 6'h00;
    if (!ctrl[0]) begin
      if (s inside {[4'h6:4'h8]}) g = 6'h10;
      if (s == 4'h0 && PORT_OVC_OFF[p]) a = 6'h10;
    end else if (PORT_OVC[p]) a = 6'h10;
    else if (PORT_BABBLE[p]) g = 6'h08;
    else case (man[3*p+:3])
      3'h1: a = 6'h10;
      3'h2: g = 6'h10;
      3'h3: g = 6'h08;
      3'h4: a = 6'h08;
      default: ;
    endcase
    return {g, a};
  endfunction : expc
  initial begin : main
    int m, i, p;
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    `CHK({LED_GREEN, LED_AMBER}, 8'hFF)
    for (i = 0; i < 4; i++) begin
      ahb(1'b0, {i[5:0], 2'b00}, 32'h0);
      `CHK(rd, 32'h0000_0000)
    end
    for (m = 0; m < 4; m++) begin
      for (i = 0; i < 12; i++) begin
        ctrl = {1'b0, m[1:0]};
        for (p = 0; p < 4; p++) // never the reserved code
          man[3*p+:3] = 3'($unsigned($random(seed)) % 5);
        ahb(1'b1, 8'h00, {29'h0, ctrl});
        ahb(1'b1, 8'h04, {20'h0, man});
        ahb(1'b0, 8'h04, 32'h0);
        `CHK(rd[11:0], man)
        ahb(1'b0, 8'h08, 32'h0);
        `CHK(rd[8], ctrl[0])
        PORT_STATE <= (i == 0) ? 16'h8760 : 16'($random(seed));
        {PORT_OVC_OFF, PORT_OVC, PORT_BABBLE} <=
          12'($random(seed) & $random(seed));
        win(16);
        for (p = 0; p < 4; p++)
          `CHK(got[p], expc(p))
      end
    end
    for (m = 4; m < 8; m += 2) begin
      ctrl = m[2:0];
      ahb(1'b1, 8'h00, {29'h0, ctrl});
      PORT_STATE <= 16'h6666;
      PORT_OVC_OFF <= 4'h0;
      win(40);
      for (p = 0; p < 4; p++)
        `CHK(got[p], 12'h500)
    end
    tally_and_finish();
  end
endmodule : port_indicator_led_control_tb
